// ### common/prhg_defs.vh
// constants for the physical rng health gate
`ifndef PRHG_DEFS_VH
`define PRHG_DEFS_VH
// total-failure test: longest run of equal raw bits tolerated
`define PRHG_TF_RUN_MAX      8'h20
// online test: window length in raw bits, and bounds on ones per window
`define PRHG_OT_WIN_LEN      12'h400
`define PRHG_OT_ONES_MIN     12'h1A0
`define PRHG_OT_ONES_MAX     12'h260
// start-up: number of passing online windows before output opens
`define PRHG_STARTUP_WINS    4'h1
// block width of the continuous compare
`define PRHG_BLK_W           16
// fifo geometry
`define PRHG_FIFO_W          16
`define PRHG_FIFO_DEPTH      32
`define PRHG_FIFO_AW         5
// gate states
`define PRHG_ST_IDLE         2'h0
`define PRHG_ST_START        2'h1
`define PRHG_ST_RUN          2'h2
`define PRHG_ST_FAIL         2'h3
`endif

// ### hw/prhg_fifo.v
// synchronous fifo with valid/ready on both sides and registered read data
`timescale 1ns/100ps
module prhg_fifo #(
   parameter W  = 16,
   parameter D  = 32,
   parameter AW = 5
) (
   clk,
   resetn,
   ce,
   flush,
   in_valid,
   in_ready,
   in_data,
   out_valid,
   out_ready,
   out_data
);
   input  wire          clk;
   input  wire          resetn;
   input  wire          ce;
   input  wire          flush;
   input  wire          in_valid;
   output wire          in_ready;
   input  wire [W-1:0]  in_data;
   output wire          out_valid;
   input  wire          out_ready;
   output reg  [W-1:0]  out_data;

   reg [W-1:0]  mem [0:D-1];
   reg [AW:0]   wr_q;
   reg [AW:0]   rd_q;
   reg          ov_q;
   wire [AW:0]  cnt = wr_q - rd_q;
   wire         full  = (cnt == D[AW:0]);
   wire         empty = (cnt == {(AW+1){1'b0}});
   wire         pop   = (~ov_q | out_ready) & ~empty;
   wire         push  = in_valid & ~full;

   assign in_ready  = ~full;
   assign out_valid = ov_q;

   // ****************************************************
   // storage and pointers
   // ****************************************************
   always @(posedge clk) begin
      if (ce & push) begin
         mem[wr_q[AW-1:0]] <= in_data;
      end
   end

   // pointers and output register, flush drops everything
   always @(posedge clk) begin
      if (!resetn) begin
         wr_q     <= {(AW+1){1'b0}};
         rd_q     <= {(AW+1){1'b0}};
         ov_q     <= 1'b0;
         out_data <= {W{1'b0}};
      end else if (ce) begin
         if (flush) begin
            wr_q <= {(AW+1){1'b0}};
            rd_q <= {(AW+1){1'b0}};
            ov_q <= 1'b0;
         end else begin
            if (push) begin
               wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
               out_data <= mem[rd_q[AW-1:0]];
               rd_q     <= rd_q + 1'b1;
               ov_q     <= 1'b1;
            end else if (out_ready) begin
               ov_q <= 1'b0;
            end
         end
      end
   end
endmodule // prhg_fifo

// ### hw/prhg_gate.v
// health-gated physical random word source
// Overview of operation
// - total-failure check from start; failure blocks output
// - drop words built from post-failure raw bits
// - online statistical test at start and always
// - no output before start-up test passes
// - test runs continuously, bounded detection window
// - consumer selects 8- or 16-bit words
// - entropy quality belongs to the analog source
// - compare each new block with previous one
`timescale 1ns/100ps
`include "prhg_defs.vh"
module prhg_gate #(
   parameter TF_RUN_MAX = `PRHG_TF_RUN_MAX,
   parameter OT_WIN     = `PRHG_OT_WIN_LEN,
   parameter OT_MIN     = `PRHG_OT_ONES_MIN,
   parameter OT_MAX     = `PRHG_OT_ONES_MAX
) (
   clk,
   resetn,
   ce,
   start,
   restart,
   raw_bit,
   raw_valid,
   word16_sel,
   rnd_valid,
   rnd_ready,
   rnd_data,
   fail_flag,
   tf_fail,
   ct_fail,
   ot_fail,
   running
);
   input  wire         clk;
   input  wire         resetn;
   input  wire         ce;
   input  wire         start;
   input  wire         restart;
   input  wire         raw_bit;
   input  wire         raw_valid;
   input  wire         word16_sel;
   output wire         rnd_valid;
   input  wire         rnd_ready;
   output wire [15:0]  rnd_data;
   output reg          fail_flag;
   output reg          tf_fail;
   output reg          ct_fail;
   output reg          ot_fail;
   output wire         running;

   localparam BW = `PRHG_BLK_W;

   // ****************************************************
   // state and datapath registers
   // ****************************************************
   reg [1:0]     st_q;
   reg [7:0]     run_q;
   reg           last_q;
   reg [11:0]    win_q;
   reg [11:0]    ones_q;
   reg [3:0]     okw_q;
   reg [BW-1:0]  sh_q;
   reg [4:0]     nb_q;
   reg [BW-1:0]  prev_q;
   reg           prev_ok_q;
   reg           wsel_q;
   reg [15:0]    wd_q;
   reg           wv_q;
   wire          f_ready;
   wire          f_ovalid;
   wire [15:0]   f_odata;

   // bits needed per word for the selected width
   function [4:0] word_bits;
      input sel16;
      begin
         word_bits = sel16 ? 5'h10 : 5'h08;
      end
   endfunction

   wire take    = (st_q == `PRHG_ST_START || st_q == `PRHG_ST_RUN) & raw_valid;
   wire same    = (raw_bit == last_q);
   wire tf_hit  = take & same & (run_q >= TF_RUN_MAX[7:0] - 8'h01);
   wire [11:0] ones_n = ones_q + {11'h000, raw_bit};
   wire win_end = take & (win_q == OT_WIN[11:0] - 12'h001);
   wire ot_hit  = win_end & ((ones_n < OT_MIN[11:0]) | (ones_n > OT_MAX[11:0]));
   wire [BW-1:0] sh_n = {sh_q[BW-2:0], raw_bit};                               // raw bits used unaltered
   wire blk_end = take & (nb_q == word_bits(wsel_q) - 5'h01);
   wire [15:0] blk  = wsel_q ? sh_n : {8'h00, sh_n[7:0]};
   wire ct_hit  = blk_end & prev_ok_q & (blk == prev_q);
   wire any_hit = tf_hit | ot_hit | ct_hit;

   assign running   = (st_q == `PRHG_ST_RUN);
   // output closed whenever not running and healthy
   assign rnd_valid = f_ovalid & running & ~fail_flag;
   assign rnd_data  = f_odata;

   // ****************************************************
   // health state machine
   // ****************************************************
   always @(posedge clk) begin
      if (!resetn) begin
         st_q      <= `PRHG_ST_IDLE;
         fail_flag <= 1'b0;
         tf_fail   <= 1'b0;
         ct_fail   <= 1'b0;
         ot_fail   <= 1'b0;
         okw_q     <= 4'h0;
      end else if (ce) begin
         case (st_q)
            `PRHG_ST_IDLE: begin
               if (start | restart) begin
                  st_q  <= `PRHG_ST_START;
                  okw_q <= 4'h0;
               end
            end
            `PRHG_ST_START: begin
               if (any_hit) begin
                  st_q <= `PRHG_ST_FAIL;
               end else if (win_end) begin
                  if (okw_q + 4'h1 >= `PRHG_STARTUP_WINS) begin
                     st_q <= `PRHG_ST_RUN;
                  end
                  okw_q <= okw_q + 4'h1;
               end
            end
            `PRHG_ST_RUN: begin
               if (any_hit) begin
                  st_q <= `PRHG_ST_FAIL;
               end
            end
            `PRHG_ST_FAIL: begin
               if (restart) begin
                  st_q      <= `PRHG_ST_START;
                  okw_q     <= 4'h0;
                  fail_flag <= 1'b0;
                  tf_fail   <= 1'b0;
                  ct_fail   <= 1'b0;
                  ot_fail   <= 1'b0;
               end
            end
            default: begin
               st_q <= `PRHG_ST_FAIL;
            end
         endcase
         // sticky flags, set wins over restart
         if (any_hit) begin
            fail_flag <= 1'b1;
         end
         if (tf_hit) begin
            tf_fail <= 1'b1;
         end
         if (ct_hit) begin
            ct_fail <= 1'b1;
         end
         if (ot_hit) begin
            ot_fail <= 1'b1;
         end
      end
   end

   // ****************************************************
   // raw bit tests and word assembly
   // ****************************************************
   always @(posedge clk) begin
      if (!resetn) begin
         run_q     <= 8'h00;
         last_q    <= 1'b0;
         win_q     <= 12'h000;
         ones_q    <= 12'h000;
         sh_q      <= {BW{1'b0}};
         nb_q      <= 5'h00;
         prev_q    <= {BW{1'b0}};
         prev_ok_q <= 1'b0;
         wsel_q    <= 1'b0;
         wd_q      <= 16'h0000;
         wv_q      <= 1'b0;
      end else if (ce) begin
         if (st_q == `PRHG_ST_IDLE || st_q == `PRHG_ST_FAIL) begin
            // width latched at (re)start, tests restart clean
            wsel_q    <= word16_sel;
            run_q     <= 8'h00;
            win_q     <= 12'h000;
            ones_q    <= 12'h000;
            nb_q      <= 5'h00;
            prev_ok_q <= 1'b0;
            wv_q      <= 1'b0;
         end else if (take) begin
            run_q  <= same ? run_q + 8'h01 : 8'h00;
            last_q <= raw_bit;
            win_q  <= win_end ? 12'h000 : win_q + 12'h001;
            ones_q <= win_end ? 12'h000 : ones_n;
            sh_q   <= sh_n;
            nb_q   <= blk_end ? 5'h00 : nb_q + 5'h01;
            if (blk_end) begin
               prev_q    <= blk;
               prev_ok_q <= 1'b1;
            end
         end
         // completed healthy block becomes a candidate word
         if (wv_q & f_ready) begin
            wv_q <= 1'b0;
         end
         if (blk_end & ~any_hit & running) begin
            wd_q <= blk;
            wv_q <= 1'b1;
         end
      end
   end

   // ****************************************************
   // output buffer, flushed on any failure
   // ****************************************************
   prhg_fifo #(
      .W  (`PRHG_FIFO_W),
      .D  (`PRHG_FIFO_DEPTH),
      .AW (`PRHG_FIFO_AW)
   ) u_fifo (
      .clk       (clk),
      .resetn    (resetn),
      .ce        (ce),
      .flush     (any_hit | (st_q == `PRHG_ST_FAIL)),
      .in_valid  (wv_q & running & ~any_hit),
      .in_ready  (f_ready),
      .in_data   (wd_q),
      .out_valid (f_ovalid),
      .out_ready (rnd_ready & running & ~fail_flag),
      .out_data  (f_odata)
   );
endmodule // prhg_gate

// ### tb/prhg_gate_properties.sv
// port checks for the rng health gate
`timescale 1ns/100ps
module prhg_gate_properties (
   input wire        clk,
   input wire        resetn,
   input wire        ce,
   input wire        start,
   input wire        restart,
   input wire        raw_bit,
   input wire        raw_valid,
   input wire        word16_sel,
   input wire        rnd_valid,
   input wire        rnd_ready,
   input wire [15:0] rnd_data,
   input wire        fail_flag,
   input wire        tf_fail,
   input wire        ct_fail,
   input wire        ot_fail,
   input wire        running
);
   // ****
   // output gating and sticky flags
   // ****
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   property p_open_only_running; rnd_valid |-> running; endproperty
   a_open_only_running: assert property (p_open_only_running) else $error("word while closed");
   property p_closed_on_fail; fail_flag |-> !rnd_valid && !running; endproperty
   a_closed_on_fail: assert property (p_closed_on_fail) else $error("word after failure");
   property p_tf_sticky; tf_fail && !restart |=> tf_fail; endproperty
   a_tf_sticky: assert property (p_tf_sticky) else $error("total flag lost");
   property p_ct_sticky; ct_fail && !restart |=> ct_fail; endproperty
   a_ct_sticky: assert property (p_ct_sticky) else $error("compare flag lost");
   property p_ot_sticky; ot_fail && !restart |=> ot_fail; endproperty
   a_ot_sticky: assert property (p_ot_sticky) else $error("online flag lost");
   property p_flags_join; tf_fail || ct_fail || ot_fail |-> ##[0:1] fail_flag; endproperty
   a_flags_join: assert property (p_flags_join) else $error("summary flag missing");
   property p_word_holds; rnd_valid && !rnd_ready |=> (rnd_valid && $stable(rnd_data)) || fail_flag; endproperty
   a_word_holds: assert property (p_word_holds) else $error("word dropped");
   property p_reset_clears; $rose(resetn) |-> !fail_flag && !running && !rnd_valid; endproperty
   a_reset_clears: assert property (p_reset_clears) else $error("state after reset");
   c_take: cover property (rnd_valid && rnd_ready);
   c_tf: cover property ($rose(tf_fail));
   c_ot: cover property ($rose(ot_fail));
   c_ct: cover property ($rose(ct_fail));
endmodule // prhg_gate_properties
bind prhg_gate prhg_gate_properties u_props (.clk, .resetn, .ce, .start, .restart, .raw_bit, .raw_valid,
   .word16_sel, .rnd_valid, .rnd_ready, .rnd_data, .fail_flag, .tf_fail, .ct_fail, .ot_fail, .running);

// ### tb/prhg_consumer.sv
// consumer model taking words at a random pace
`timescale 1ns/100ps
module prhg_consumer (
   input  wire clk,
   input  wire hold,
   input  wire fail_flag,
   input  wire rnd_valid,
   output reg  rnd_ready
);
   // ****
   // pace
   // ****
   initial rnd_ready = 1'b0;
   // ready off while held or failed, else two of three cycles
   always @(negedge clk) begin
      rnd_ready <= !hold && !fail_flag && ($urandom % 3 != 0);
   end
endmodule // prhg_consumer

// ### tb/testbench.sv
// self-checking bench for the rng health gate
`timescale 1ns/100ps
module testbench;
   // ****
   // stimulus and scoreboard
   // ****
   reg         clk, resetn, ce, start, restart, raw_bit, raw_valid, word16_sel, hold;
   wire        rnd_valid, rnd_ready, fail_flag, tf_fail, ct_fail, ot_fail, running;
   wire [15:0] rnd_data;
   wire [15:0] flag_vec = {11'h000, fail_flag, tf_fail, ct_fail, ot_fail, running};
   reg  [15:0] exp_q[$];
   reg  [15:0] prev;
   integer     failures, checks, cyc, k;
   prhg_gate #(.TF_RUN_MAX(8), .OT_WIN(64), .OT_MIN(26), .OT_MAX(38)) uut (.clk, .resetn, .ce, .start,
      .restart, .raw_bit, .raw_valid, .word16_sel, .rnd_valid, .rnd_ready, .rnd_data, .fail_flag, .tf_fail,
      .ct_fail, .ot_fail, .running);
   prhg_consumer u_cons (.clk, .hold, .fail_flag, .rnd_valid, .rnd_ready);
   always #5 clk = ~clk;
   task check(input [15:0] seen, input [15:0] exp);
      begin
         checks = checks + 1;
         if (seen !== exp) begin
            failures = failures + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task end_of_test;
      begin
         if (failures == 0 && checks > 0) $display("Finished cleanly");
         else $display("Finished with errors");
         $finish;
      end
   endtask
   // one qualified raw bit, random idle gaps with random clock enable
   task put_bit(input b);
      begin
         while ($urandom % 4 == 0) begin
            raw_valid = 0;
            ce = ($urandom % 2) != 0;
            @(negedge clk);
         end
         ce = 1;
         raw_bit = b;
         raw_valid = 1;
         @(negedge clk);
      end
   endtask
   // word of complementary bit pairs, differing from the last one unless dup repeats it
   task put_word(input n16, input push, input dup);
      reg [15:0] w;
      integer i;
      begin
         w = $urandom;
         for (i = 0; i < 8; i = i + 1) w[2*i] = ~w[2*i+1];
         if (!n16) w[15:8] = 8'h00;
         if (w == prev) w = w ^ 16'h0003;
         if (dup) w = prev;
         prev = w;
         if (push) exp_q.push_back(w);
         for (i = n16 ? 15 : 7; i >= 0; i = i - 1) put_bit(w[i]);
      end
   endtask
   task drain;
      integer n;
      begin
         raw_valid = 0;
         for (n = 0; n < 300 && (exp_q.size() > 0 || rnd_valid); n = n + 1) @(negedge clk);
         repeat (4) @(negedge clk);
         check(16'(exp_q.size()), 16'h0000);
      end
   endtask
   // start (taken in idle), restart (taken in fail), one window of start-up words
   task boot(input n16);
      begin
         word16_sel = n16;
         start = 1;
         @(negedge clk);
         start = 0;
         restart = 1;
         @(negedge clk);
         restart = 0;
         for (k = 1; k < (n16 ? 4 : 8); k = k + 1) put_word(n16, 0, 0);
         check(flag_vec, 16'h0000);
         put_word(n16, 0, 0);
         raw_valid = 0;
         repeat (4) @(negedge clk);
         check(flag_vec, 16'h0001);
      end
   endtask
   // result watcher: every taken word against the oldest note
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (rnd_valid === 1'b1 && rnd_ready === 1'b1 && ce === 1'b1) begin
         if (exp_q.size() == 0) check(rnd_data, ~rnd_data);
         else check(rnd_data, exp_q.pop_front());
      end
      if (cyc == 20000) begin
         failures = failures + 1;
         end_of_test;
      end
   end
   initial begin
      clk = 0; resetn = 0; ce = 1; start = 0; restart = 0; raw_bit = 0; raw_valid = 0;
      word16_sel = 0; hold = 0; prev = 0; failures = 0; checks = 0; cyc = 0;
      void'($urandom(32'h9DA9B5C7));
      repeat (8) @(negedge clk);
      resetn = 1;
      // byte words to a consumer ready two of three cycles
      boot(0);
      for (k = 0; k < 12; k = k + 1) put_word(0, 1, 0);
      drain;
      // run of equal bits, later bits must stay out
      hold = 1;
      for (k = 0; k < 12; k = k + 1) put_bit(0);
      put_word(0, 0, 0);
      drain;
      check(flag_vec, 16'h0018);
      hold = 0;
      // restart clears, 16-bit words, then a repeated word
      boot(1);
      for (k = 0; k < 6; k = k + 1) put_word(1, 1, 0);
      drain;
      hold = 1;
      put_word(1, 0, 1);
      drain;
      check(flag_vec, 16'h0014);
      hold = 0;
      // biased window with short runs
      boot(0);
      hold = 1;
      for (k = 0; k < 64; k = k + 1) put_bit(k % 3 != 2);
      drain;
      check(flag_vec, 16'h0012);
      hold = 0;
      repeat (20) @(negedge clk);
      // second reset while in the failed state
      resetn = 0;
      repeat (2) @(negedge clk);
      resetn = 1;
      @(negedge clk);
      check(flag_vec, 16'h0000);
      // start from idle after the second reset
      boot(1);
      end_of_test;
   end
endmodule // testbench
